// File: rtl/fault_irq_pkg.sv
/*
 * Constants for the fault interrupt enable bank: register offsets,
 * two-bit enable codes, field positions and reset states.
 * Assumes a 16-bit register port fed by the device's serial interface engine.
 */
package fault_irq_pkg;

    // ========================================================
    // Register map
    localparam logic [7:0]  SUPPLY_EN_OFF   = 8'h08;
    localparam logic [7:0]  BOOST_EN_OFF    = 8'h0A;
    localparam logic [7:0]  LED_EN_OFF      = 8'h0C;
    localparam logic [15:0] SUPPLY_EN_RST   = 16'h2AAA;
    localparam logic [15:0] BOOST_EN_RST    = 16'hA028;
    localparam logic [15:0] LED_EN_RST      = 16'h00AA;

    // ========================================================
    // Two-bit enable codes
    localparam logic [1:0]  RD_DISABLED     = 2'h0;
    localparam logic [1:0]  RD_ENABLED      = 2'h2;
    localparam logic [1:0]  WR_DISABLE      = 2'h1;
    localparam logic [1:0]  WR_ENABLE       = 2'h3;

    // ========================================================
    // Field slots: slot i occupies bits 2i+1..2i
    localparam int          SYNC_LOSS_SLOT  = 6;
    localparam int          PUMP_FAULT_SLOT = 5;
    localparam int          PUMP_CAP_SLOT   = 4;
    localparam int          IN_OC_SLOT      = 3;
    localparam int          CORE_UV_SLOT    = 2;
    localparam int          IN_OV_SLOT      = 1;
    localparam int          IN_UV_SLOT      = 0;
    localparam int          THERMAL_SLOT    = 7;
    localparam int          CUR_RES_SLOT    = 6;
    localparam int          STR_RES_SLOT    = 5;
    localparam int          MODE_RES_SLOT   = 4;
    localparam int          FREQ_RES_SLOT   = 3;
    localparam int          CONV_OC_SLOT    = 2;
    localparam int          CONV_OV_SLOT    = 1;
    localparam int          GLOBAL_SLOT     = 3;
    localparam int          BUS_TMO_SLOT    = 2;
    localparam int          BAD_CFG_SLOT    = 1;
    localparam int          STRING_SLOT     = 0;

    // Implemented slots and their reset enables; reserved slots hold zero
    localparam logic [7:0]  SUPPLY_SLOTS    = 8'h7F;
    localparam logic [7:0]  BOOST_SLOTS     = 8'hFE;
    localparam logic [7:0]  LED_SLOTS       = 8'h0F;
    localparam logic [7:0]  SUPPLY_RST_EN   = 8'h7F;
    localparam logic [7:0]  BOOST_RST_EN    = 8'hC6;
    localparam logic [7:0]  LED_RST_EN      = 8'h0F;

    // ========================================================
    // Readback: each enabled slot shows code 2h, every other slot 0h
    function automatic logic [15:0] enable_readback(input logic [7:0] en);
        logic [15:0] v;
        v = 16'h0000;
        for (int i = 0; i < 8; i++) begin
            v[2*i +: 2] = en[i] ? RD_ENABLED : RD_DISABLED;
        end
        return v;
    endfunction

endpackage

// File: rtl/enable_field_bank.sv
/*
 * One 16-bit register of eight two-bit interrupt enable fields with
 * coded writes. Holds one bit of state per implemented field.
 * Assumes wr is a single-cycle strobe already decoded for this register.
 */
module enable_field_bank #(
    parameter logic [7:0] SLOTS  = 8'hFF,
    parameter logic [7:0] RST_EN = 8'h00
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        wr,
    input  wire logic [15:0] wdata,
    output logic      [7:0]  en_r
);
    import fault_irq_pkg::*;

    logic [7:0] en_nxt;

    // ========================================================
    // Coded update; only the two write codes move a field so a stray
    // pattern of all zeros or a read-back value written again is harmless
    always_comb begin
        en_nxt = en_r;
        for (int i = 0; i < 8; i++) begin
            if (wr && SLOTS[i]) begin
                if (wdata[2*i +: 2] == WR_ENABLE) begin
                    en_nxt[i] = 1'b1;
                end else if (wdata[2*i +: 2] == WR_DISABLE) begin
                    en_nxt[i] = 1'b0;
                end
            end
        end
        // Reserved slots never take state, whatever code lands on them
        en_nxt = en_nxt & SLOTS;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            en_r <= RST_EN;
        end else begin
            en_r <= en_nxt;
        end
    end

endmodule // enable_field_bank

// File: rtl/fault_interrupt_enable_bank.sv
/*
 * Fault interrupt enable bank: three coded enable registers, read port and
 * the gated interrupt request built from the fault status flags.
 * Assumes the serial interface engine presents single-cycle read and write
 * strobes with a byte offset, and that status flags are synchronous levels.
 */
module fault_interrupt_enable_bank (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [6:0]  supply_fault_status,
    input  wire logic [6:0]  boost_fault_status,
    input  wire logic [2:0]  led_fault_status,
    output logic      [15:0] rd_data_r,
    output logic             rd_valid_r,
    output logic             irq_r
);
    import fault_irq_pkg::*;

    logic [7:0]  supply_en;
    logic [7:0]  boost_en;
    logic [7:0]  led_en;
    logic        wr_supply;
    logic        wr_boost;
    logic        wr_led;
    logic [15:0] rd_data_nxt;
    logic        rd_valid_nxt;
    logic        irq_nxt;
    logic [7:0]  supply_stat;
    logic [7:0]  boost_stat;
    logic [7:0]  led_stat;

    // ========================================================
    // Write decode
    assign wr_supply = reg_wr && (reg_addr == SUPPLY_EN_OFF);
    assign wr_boost  = reg_wr && (reg_addr == BOOST_EN_OFF);
    assign wr_led    = reg_wr && (reg_addr == LED_EN_OFF);

    enable_field_bank #(
        .SLOTS  (SUPPLY_SLOTS),
        .RST_EN (SUPPLY_RST_EN)
    ) u_supply (
        .clk   (clk),
        .rst   (rst),
        .wr    (wr_supply),
        .wdata (reg_wdata),
        .en_r  (supply_en)
    );

    enable_field_bank #(
        .SLOTS  (BOOST_SLOTS),
        .RST_EN (BOOST_RST_EN)
    ) u_boost (
        .clk   (clk),
        .rst   (rst),
        .wr    (wr_boost),
        .wdata (reg_wdata),
        .en_r  (boost_en)
    );

    enable_field_bank #(
        .SLOTS  (LED_SLOTS),
        .RST_EN (LED_EN_RST[7:0] == 8'hAA ? LED_RST_EN : 8'h00)
    ) u_led (
        .clk   (clk),
        .rst   (rst),
        .wr    (wr_led),
        .wdata (reg_wdata),
        .en_r  (led_en)
    );

    // ========================================================
    // Status flags lined up with their enable slots
    assign supply_stat = {1'b0, supply_fault_status};
    assign boost_stat  = {boost_fault_status, 1'b0};
    assign led_stat    = {5'h00, led_fault_status};

    // ========================================================
    // Read port and interrupt request; unmapped offsets read zero
    always_comb begin
        rd_valid_nxt = reg_rd;
        rd_data_nxt  = rd_data_r;
        if (reg_rd) begin
            unique case (reg_addr)
                SUPPLY_EN_OFF: rd_data_nxt = enable_readback(supply_en);
                BOOST_EN_OFF:  rd_data_nxt = enable_readback(boost_en);
                LED_EN_OFF:    rd_data_nxt = enable_readback(led_en);
                default:       rd_data_nxt = 16'h0000;
            endcase
        end
        // Registered so the pin never glitches on a status edge
        irq_nxt = led_en[GLOBAL_SLOT] &&
                  (|(supply_stat & supply_en) ||
                   |(boost_stat & boost_en) ||
                   |(led_stat & led_en & 8'h07));
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data_r  <= 16'h0000;
            rd_valid_r <= 1'b0;
            irq_r      <= 1'b0;
        end else begin
            rd_data_r  <= rd_data_nxt;
            rd_valid_r <= rd_valid_nxt;
            irq_r      <= irq_nxt;
        end
    end

    // ========================================================
    // Checks
    chk_read_codes: assert property (@(posedge clk) disable iff (rst)
        rd_valid_r |-> ((rd_data_r & 16'h5555) == 16'h0000))
        else $error("read code other than 0h or 2h");

    chk_write_enable: assert property (@(posedge clk) disable iff (rst)
        (wr_boost && reg_wdata[2*STR_RES_SLOT +: 2] == WR_ENABLE) ##1 (reg_rd && reg_addr == BOOST_EN_OFF)
        |=> rd_data_r[2*STR_RES_SLOT +: 2] == RD_ENABLED)
        else $error("enable write not read back as 2h");

    chk_write_disable: assert property (@(posedge clk) disable iff (rst)
        (wr_supply && reg_wdata[2*SYNC_LOSS_SLOT +: 2] == WR_DISABLE) |=> !supply_en[SYNC_LOSS_SLOT])
        else $error("disable write did not clear enable");

    chk_hold_code: assert property (@(posedge clk) disable iff (rst)
        (wr_led && !reg_wdata[2*STRING_SLOT]) |=> $stable(led_en[STRING_SLOT]))
        else $error("write code 0h or 2h changed enable");

    chk_supply_reserved: assert property (@(posedge clk) disable iff (rst)
        (reg_rd && reg_addr == SUPPLY_EN_OFF) |=> (rd_data_r[15:14] == 2'h0))
        else $error("supply reserved bits not zero");

    chk_boost_reserved: assert property (@(posedge clk) disable iff (rst)
        (reg_rd && reg_addr == BOOST_EN_OFF) |=> (rd_data_r[1:0] == 2'h0))
        else $error("boost reserved bits not zero");

    chk_led_reserved: assert property (@(posedge clk) disable iff (rst)
        (reg_rd && reg_addr == LED_EN_OFF) |=> (rd_data_r[15:8] == 8'h00))
        else $error("led upper byte not zero");

    chk_reset_state: assert property (@(posedge clk)
        $fell(rst) |-> (enable_readback(supply_en) == SUPPLY_EN_RST &&
                         enable_readback(boost_en) == BOOST_EN_RST &&
                         enable_readback(led_en) == LED_EN_RST))
        else $error("enable state differs from reset value");

    chk_irq_gate: assert property (@(posedge clk) disable iff (rst)
        irq_r |-> $past(led_en[GLOBAL_SLOT]) && $past(|(supply_stat & supply_en) ||
                  |(boost_stat & boost_en) || |(led_stat & led_en & 8'h07)))
        else $error("interrupt without enabled fault");

    chk_irq_raise: assert property (@(posedge clk) disable iff (rst)
        (led_en[GLOBAL_SLOT] && supply_fault_status[IN_UV_SLOT] && supply_en[IN_UV_SLOT]) |=> irq_r)
        else $error("enabled fault did not raise interrupt");

    // ========================================================
    // Reset code of every field except the global enable, pinned one by one so a slip in the package masks shows up
    chk_sync_loss_rst: assert property (@(posedge clk)
        $fell(rst) |-> supply_en[SYNC_LOSS_SLOT])
        else $error("sync loss enable not set after reset");

    chk_pump_fault_rst: assert property (@(posedge clk)
        $fell(rst) |-> supply_en[PUMP_FAULT_SLOT])
        else $error("pump fault enable not set after reset");

    chk_pump_cap_rst: assert property (@(posedge clk)
        $fell(rst) |-> supply_en[PUMP_CAP_SLOT])
        else $error("pump capacitor enable not set after reset");

    chk_in_oc_rst: assert property (@(posedge clk)
        $fell(rst) |-> supply_en[IN_OC_SLOT])
        else $error("input over-current enable not set after reset");

    chk_core_uv_rst: assert property (@(posedge clk)
        $fell(rst) |-> supply_en[CORE_UV_SLOT])
        else $error("core under-voltage enable not set after reset");

    chk_in_ov_rst: assert property (@(posedge clk)
        $fell(rst) |-> supply_en[IN_OV_SLOT])
        else $error("input over-voltage enable not set after reset");

    chk_in_uv_rst: assert property (@(posedge clk)
        $fell(rst) |-> supply_en[IN_UV_SLOT])
        else $error("input under-voltage enable not set after reset");

    chk_thermal_rst: assert property (@(posedge clk)
        $fell(rst) |-> boost_en[THERMAL_SLOT])
        else $error("thermal enable not set after reset");

    chk_cur_res_rst: assert property (@(posedge clk)
        $fell(rst) |-> boost_en[CUR_RES_SLOT])
        else $error("current resistor enable not set after reset");

    chk_str_res_rst: assert property (@(posedge clk)
        $fell(rst) |-> !boost_en[STR_RES_SLOT])
        else $error("string-config resistor enable set after reset");

    chk_mode_res_rst: assert property (@(posedge clk)
        $fell(rst) |-> !boost_en[MODE_RES_SLOT])
        else $error("dimming-mode resistor enable set after reset");

    chk_freq_res_rst: assert property (@(posedge clk)
        $fell(rst) |-> !boost_en[FREQ_RES_SLOT])
        else $error("frequency resistor enable set after reset");

    chk_conv_oc_rst: assert property (@(posedge clk)
        $fell(rst) |-> boost_en[CONV_OC_SLOT])
        else $error("converter over-current enable not set after reset");

    chk_conv_ov_rst: assert property (@(posedge clk)
        $fell(rst) |-> boost_en[CONV_OV_SLOT])
        else $error("converter over-voltage enable not set after reset");

    chk_bus_tmo_rst: assert property (@(posedge clk)
        $fell(rst) |-> led_en[BUS_TMO_SLOT])
        else $error("bus time-out enable not set after reset");

    chk_bad_cfg_rst: assert property (@(posedge clk)
        $fell(rst) |-> led_en[BAD_CFG_SLOT])
        else $error("bad string config enable not set after reset");

    chk_string_rst: assert property (@(posedge clk)
        $fell(rst) |-> led_en[STRING_SLOT])
        else $error("string fault enable not set after reset");

    // ========================================================
    // Reserved slots, read port timing, interrupt gating and coded writes
    chk_supply_spare: assert property (@(posedge clk) disable iff (rst)
        !supply_en[7])
        else $error("supply reserved slot holds state");

    chk_boost_spare: assert property (@(posedge clk) disable iff (rst)
        !boost_en[0])
        else $error("boost reserved slot holds state");

    chk_led_spare: assert property (@(posedge clk) disable iff (rst)
        led_en[7:4] == 4'h0)
        else $error("led reserved slots hold state");

    chk_read_hold: assert property (@(posedge clk) disable iff (rst)
        !reg_rd |=> $stable(rd_data_r))
        else $error("read data moved without a read");

    chk_valid_pulse: assert property (@(posedge clk) disable iff (rst)
        reg_rd |=> rd_valid_r)
        else $error("read not marked valid");

    chk_valid_idle: assert property (@(posedge clk) disable iff (rst)
        !reg_rd |=> !rd_valid_r)
        else $error("valid without a read");

    chk_unmapped_read: assert property (@(posedge clk) disable iff (rst)
        (reg_rd && reg_addr != SUPPLY_EN_OFF && reg_addr != BOOST_EN_OFF && reg_addr != LED_EN_OFF)
        |=> rd_data_r == 16'h0000)
        else $error("unmapped read not zero");

    chk_global_gate: assert property (@(posedge clk) disable iff (rst)
        !led_en[GLOBAL_SLOT] |=> !irq_r)
        else $error("interrupt with global enable off");

    chk_sync_irq: assert property (@(posedge clk) disable iff (rst)
        (led_en[GLOBAL_SLOT] && supply_fault_status[SYNC_LOSS_SLOT] && supply_en[SYNC_LOSS_SLOT]) |=> irq_r)
        else $error("sync loss fault did not raise interrupt");

    chk_thermal_irq: assert property (@(posedge clk) disable iff (rst)
        (led_en[GLOBAL_SLOT] && boost_fault_status[6] && boost_en[THERMAL_SLOT]) |=> irq_r)
        else $error("thermal fault did not raise interrupt");

    chk_conv_irq: assert property (@(posedge clk) disable iff (rst)
        (led_en[GLOBAL_SLOT] && boost_fault_status[0] && boost_en[CONV_OV_SLOT]) |=> irq_r)
        else $error("converter over-voltage did not raise interrupt");

    chk_bus_irq: assert property (@(posedge clk) disable iff (rst)
        (led_en[GLOBAL_SLOT] && led_fault_status[2] && led_en[BUS_TMO_SLOT]) |=> irq_r)
        else $error("bus time-out did not raise interrupt");

    chk_string_irq: assert property (@(posedge clk) disable iff (rst)
        (led_en[GLOBAL_SLOT] && led_fault_status[0] && led_en[STRING_SLOT]) |=> irq_r)
        else $error("string fault did not raise interrupt");

    chk_pump_enable: assert property (@(posedge clk) disable iff (rst)
        (wr_supply && reg_wdata[2*PUMP_FAULT_SLOT +: 2] == WR_ENABLE) |=> supply_en[PUMP_FAULT_SLOT])
        else $error("enable write did not set pump fault enable");

    chk_global_enable: assert property (@(posedge clk) disable iff (rst)
        (wr_led && reg_wdata[2*GLOBAL_SLOT +: 2] == WR_ENABLE) |=> led_en[GLOBAL_SLOT])
        else $error("enable write did not set global enable");

    chk_thermal_disable: assert property (@(posedge clk) disable iff (rst)
        (wr_boost && reg_wdata[2*THERMAL_SLOT +: 2] == WR_DISABLE) |=> !boost_en[THERMAL_SLOT])
        else $error("disable write did not clear thermal enable");

    chk_global_disable: assert property (@(posedge clk) disable iff (rst)
        (wr_led && reg_wdata[2*GLOBAL_SLOT +: 2] == WR_DISABLE) |=> !led_en[GLOBAL_SLOT])
        else $error("disable write did not clear global enable");

    cov_enable_write: cover property (@(posedge clk) disable iff (rst)
        wr_boost && reg_wdata[2*FREQ_RES_SLOT +: 2] == WR_ENABLE);
    cov_global_off: cover property (@(posedge clk) disable iff (rst)
        wr_led && reg_wdata[2*GLOBAL_SLOT +: 2] == WR_DISABLE);
    cov_irq: cover property (@(posedge clk) disable iff (rst) $rose(irq_r));
    cov_unmapped: cover property (@(posedge clk) disable iff (rst)
        reg_rd && reg_addr != SUPPLY_EN_OFF && reg_addr != BOOST_EN_OFF && reg_addr != LED_EN_OFF);
    cov_mid_reset: cover property (@(posedge clk) $rose(rst));

endmodule // fault_interrupt_enable_bank

// File: verif/test_fault_interrupt_enable_bank.sv
/*
 * Self-checking bench for the fault interrupt enable bank: a model of the three
 * coded enable registers and the gated request, compared with the design at every result.
 * Assumes the design package and design files are compiled first; inputs move 2 ns after each rising edge.
 */
module test_fault_interrupt_enable_bank import fault_irq_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // ================================================================
    // Signals and model state
    localparam logic [7:0]  OFFS [3]  = '{8'h08, 8'h0A, 8'h0C};
    localparam logic [15:0] RSTV [3]  = '{16'h2AAA, 16'hA028, 16'h00AA};
    localparam logic [7:0]  MASKS [3] = '{8'h7F, 8'hFE, 8'h0F};
    logic        clk;
    logic        rst;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [6:0]  sup_st;
    logic [6:0]  bst_st;
    logic [2:0]  led_st;
    logic [15:0] rd_data_r;
    logic        rd_valid_r;
    logic        irq_r;
    logic [7:0]  men [3];
    logic [31:0] seed;
    int          miscompares;
    int          samples_checked;

    fault_interrupt_enable_bank dut (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .supply_fault_status(sup_st), .boost_fault_status(bst_st),
        .led_fault_status(led_st), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r), .irq_r(irq_r));

    always #20 clk = ~clk;

    // ================================================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [15:0] rb(input logic [7:0] e);
        logic [15:0] v;
        v = 16'h0000;
        for (int i = 0; i < 8; i++) v[2*i +: 2] = e[i] ? 2'h2 : 2'h0;
        return v;
    endfunction

    function automatic int idx(input logic [7:0] a);
        for (int k = 0; k < 3; k++) if (a == OFFS[k]) return k;
        return -1;
    endfunction

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            miscompares++;
        end
    endtask

    task automatic finish_test();
        if (miscompares == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ================================================================
    // Bus cycles and model updates
    task automatic do_reset();
        rst = 1'b1;
        repeat (3) begin
            @(posedge clk);
            #2;
        end
        check("rd_valid_r", 16'h0000, {15'h0, rd_valid_r});
        check("irq_r", 16'h0000, {15'h0, irq_r});
        rst = 1'b0;
        for (int k = 0; k < 3; k++)
            for (int i = 0; i < 8; i++) men[k][i] = RSTV[k][2*i+1];
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        int k;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #2;
        reg_wr = 1'b0;
        k = idx(a);
        // Only the two defined codes move a field; reserved slots never hold state
        if (k >= 0)
            for (int i = 0; i < 8; i++)
                if (MASKS[k][i] && d[2*i +: 2] == 2'h3) men[k][i] = 1'b1;
                else if (MASKS[k][i] && d[2*i +: 2] == 2'h1) men[k][i] = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        int k;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #2;
        reg_rd = 1'b0;
        k = idx(a);
        check("rd_valid_r", 16'h0001, {15'h0, rd_valid_r});
        check("rd_data_r", (k < 0) ? 16'h0000 : rb(men[k]), rd_data_r);
        @(posedge clk);
        #2;
        // Valid lasts one cycle while the data stays until the next read
        check("rd_valid_r", 16'h0000, {15'h0, rd_valid_r});
        check("rd_data_r", (k < 0) ? 16'h0000 : rb(men[k]), rd_data_r);
    endtask

    task automatic irq_step();
        logic exp;
        sup_st = seed[6:0] & seed[14:8];
        bst_st = seed[22:16] & seed[30:24];
        led_st = seed[10:8] & seed[3:1];
        seed = lfsr(seed);
        exp = men[2][3] & (|(sup_st & men[0][6:0]) | |(bst_st & men[1][7:1]) | |(led_st & men[2][2:0]));
        @(posedge clk);
        #2;
        check("irq_r", {15'h0, exp}, {15'h0, irq_r});
    endtask

    // ================================================================
    // Main sequence
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        sup_st = 7'h00;
        bst_st = 7'h00;
        led_st = 3'h0;
        seed = 32'hc262;
        miscompares = 0;
        samples_checked = 0;
        #2;
        do_reset();
        for (int k = 0; k < 3; k++) rd(OFFS[k]);
        rd(8'h09);
        wr(8'h0A, 16'h0C00);
        rd(8'h0A);
        for (int n = 0; n < 300; n++) begin
            // Mostly mapped offsets, a quarter random to hit unmapped ones
            wr((seed[1:0] == 2'h3) ? seed[15:8] : OFFS[seed[1:0] % 3], seed[31:16]);
            seed = lfsr(seed);
            rd(OFFS[n % 3]);
            repeat (3) irq_step();
        end
        do_reset();
        for (int k = 0; k < 3; k++) rd(OFFS[k]);
        finish_test();
    end

    // Watchdog: the sequence needs about 1,800 cycles
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        finish_test();
    end

endmodule // test_fault_interrupt_enable_bank
